/* File: hw/ndi_pkg.sv */
// Package for the dual-die NAND interleave host controller.
// Assumes a 100 MHz system clock and an 8-bit multiplexed NAND bus.
package ndi_pkg;
  // Register offsets of the controller's own register file
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR_LO = 4'h1;
  localparam logic [3:0] REG_ADDR_HI = 4'h2;
  localparam logic [3:0] REG_DATA = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_MASK = 4'h6;
  localparam logic [3:0] REG_ID_LO = 4'h7;
  localparam logic [3:0] REG_ID_HI = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'h9;
  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DIE_BIT = 4;
  localparam int CTRL_GO_BIT = 7;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Operation codes written to the control register
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_ERASE2 = 3'h3;
  localparam logic [2:0] OP_READID = 3'h4;
  localparam logic [2:0] OP_POLL = 3'h5;
  localparam logic [2:0] OP_RDIN = 3'h6;
  localparam logic [2:0] OP_RESET = 3'h7;
  // Flash commands
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_RAND_IN = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_DIE1_STATUS = 8'hf1;
  localparam logic [7:0] CMD_DIE2_STATUS = 8'hf2;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] ID_ADDR = 8'h00;
  // Status byte decode: bit 7 always set, bit 6 is the ready bit
  localparam int STS_FIXED_BIT = 7;
  localparam int STS_READY_BIT = 6;
  // Page buffer and address layout
  localparam int PAGE_BYTES = 2112;
  localparam int COL_BITS = 12;
  localparam int ROW_BITS = 19;
  localparam int ID_BYTES = 5;
  localparam int ADDR_CYCLES = 5;
  // Bus strobe timing: each half of a strobe cycle
  localparam int T_HALF_NS = 30;
  localparam int CLK_NS = 10;
  localparam int HALF_CYC = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_D1_RDY = 1;
  localparam int IRQ_D2_RDY = 2;
  localparam int IRQ_REFUSED = 3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CMD1 = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0011,
    ST_CMD2 = 4'b0100,
    ST_IDRD = 4'b0101,
    ST_POLLC = 4'b0110,
    ST_POLLR = 4'b0111,
    ST_DONE = 4'b1000
  } ndi_state_t;
endpackage : ndi_pkg

/* File: hw/ndi_host.sv */
// Host controller driving a dual-die NAND package over its multiplexed bus.
// Assumes pin inputs synchronous to i_mclk; software on a plain strobe port.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module ndi_host (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq,
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_re_n,
  output logic [7:0] o_io,
  output logic o_io_oe,
  input wire logic [7:0] i_io,
  input wire logic i_rb_n
);
  import ndi_pkg::*;

  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [30:0] a);
    case (idx)
      3'h0: addr_byte = a[7:0];
      3'h1: addr_byte = {4'h0, a[11:8]};
      3'h2: addr_byte = a[19:12];
      3'h3: addr_byte = a[27:20];
      default: addr_byte = {5'h00, a[30:28]};
    endcase
  endfunction : addr_byte

  ndi_state_t state_q;
  logic [15:0] ctrl_q;
  logic [30:0] addr_q;
  logic [7:0] data_q;
  logic data_vld_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;
  logic [39:0] id_q;
  logic [15:0] count_q;
  logic [15:0] xfer_q;
  logic [2:0] idx_q;
  logic [3:0] tcnt_q;
  logic phase_q;
  logic [1:0] busy_q;
  logic [1:0] rdy_seen_q;
  logic poll_die_q;
  logic erase_pass_q;
  logic rdin_q;
  logic [7:0] cmd2_q;
  logic [7:0] status_q;
  logic [1:0] cmd_done_sel;
  logic step;
  logic op_start;
  logic op_refuse;
  logic [2:0] op_code;
  logic op_die;
  logic die_sts_ready;
  logic irq_done_ev;
  logic refuse_ev;

  assign op_code = i_wdata[CTRL_OP_LSB +: 3];
  assign op_die = i_wdata[CTRL_DIE_BIT];
  assign op_start = i_wr && i_addr == REG_CTRL && i_wdata[CTRL_GO_BIT] && state_q == ST_IDLE;
  // Program or erase to a die still marked busy is refused until it polls ready or a reset operation runs
  assign op_refuse = op_start && (op_code == OP_PROG || op_code == OP_ERASE ||
                     op_code == OP_ERASE2) && busy_q[op_die];
  assign refuse_ev = op_refuse || (i_wr && i_addr == REG_CTRL && i_wdata[CTRL_GO_BIT] &&
                     state_q != ST_IDLE);
  // Strobe half-period divider
  assign step = tcnt_q == 4'(HALF_CYC - 1);
  // Only bits 7 and 6 are looked at; ready needs both bits set
  assign die_sts_ready = i_io[STS_FIXED_BIT] && i_io[STS_READY_BIT];
  assign irq_done_ev = state_q == ST_DONE;
  assign cmd_done_sel = 2'(poll_die_q) + 2'h1;

  // Strobe timing counter, held while a load byte is awaited so strobe halves stay whole
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || state_q == ST_IDLE || step ||
        (state_q == ST_DATA && !phase_q && !data_vld_q)) begin
      tcnt_q <= 4'h0;
    end else begin
      tcnt_q <= tcnt_q + 4'h1;
    end
  end

  // Software registers
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ctrl_q <= CTRL_RESET;
      addr_q <= '0;
      irq_mask_q <= MASK_RESET;
    end else if (i_wr) begin
      case (i_addr)
        REG_CTRL: ctrl_q <= op_start && !op_refuse ? i_wdata : ctrl_q;
        REG_ADDR_LO: addr_q[15:0] <= i_wdata;
        REG_ADDR_HI: addr_q[30:16] <= i_wdata[14:0];
        REG_IRQ_MASK: irq_mask_q <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Write data holding byte for page loads
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      data_q <= 8'h00;
      data_vld_q <= 1'b0;
    end else if (i_wr && i_addr == REG_DATA) begin
      data_q <= i_wdata[7:0];
      data_vld_q <= 1'b1;
    end else if (state_q == ST_DATA && phase_q && step) begin
      data_vld_q <= 1'b0;
    end
  end

  // Sequencer
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      idx_q <= 3'h0;
      phase_q <= 1'b0;
      xfer_q <= 16'h0000;
      erase_pass_q <= 1'b0;
      poll_die_q <= 1'b0;
      rdin_q <= 1'b0;
      cmd2_q <= 8'h00;
      id_q <= '0;
      status_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          phase_q <= 1'b0;
          idx_q <= 3'h0;
          xfer_q <= 16'h0000;
          erase_pass_q <= 1'b0;
          if (op_start && !op_refuse) begin
            poll_die_q <= op_die;
            rdin_q <= op_code == OP_RDIN;
            case (op_code)
              OP_PROG: cmd2_q <= CMD_SERIAL_IN;
              OP_RDIN: cmd2_q <= CMD_RAND_IN;
              OP_ERASE, OP_ERASE2: cmd2_q <= CMD_ERASE_SETUP;
              OP_READID: cmd2_q <= CMD_READ_ID;
              OP_POLL: cmd2_q <= op_die ? CMD_DIE2_STATUS : CMD_DIE1_STATUS;
              default: cmd2_q <= CMD_RESET;
            endcase
            state_q <= ST_CMD1;
          end
        end
        ST_CMD1: if (step) begin
          phase_q <= !phase_q;
          if (phase_q) begin
            case (ctrl_q[CTRL_OP_LSB +: 3])
              OP_POLL: state_q <= ST_POLLR;
              OP_RESET: state_q <= ST_DONE;
              OP_READID: begin
                idx_q <= 3'h4;
                state_q <= ST_ADDR;
              end
              OP_ERASE, OP_ERASE2: begin
                idx_q <= 3'h2;
                state_q <= ST_ADDR;
              end
              default: state_q <= ST_ADDR;
            endcase
          end
        end
        ST_ADDR: if (step) begin
          phase_q <= !phase_q;
          if (phase_q) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'(ADDR_CYCLES - 1)) begin
              idx_q <= 3'h0;
              case (ctrl_q[CTRL_OP_LSB +: 3])
                OP_READID: state_q <= ST_IDRD;
                OP_ERASE2: begin
                  // Second block address follows a new setup before confirm
                  if (!erase_pass_q) begin
                    erase_pass_q <= 1'b1;
                    state_q <= ST_CMD1;
                  end else begin
                    state_q <= ST_CMD2;
                  end
                end
                OP_ERASE: state_q <= ST_CMD2;
                default: state_q <= ST_DATA;
              endcase
            end
          end
        end
        ST_DATA: if (step && (phase_q || data_vld_q)) begin
          phase_q <= !phase_q;
          if (phase_q) begin
            xfer_q <= xfer_q + 16'h1;
            if (xfer_q + 16'h1 >= count_q || xfer_q == 16'(PAGE_BYTES - 1)) begin
              state_q <= rdin_q ? ST_DONE : ST_CMD2;
            end
          end
        end
        ST_CMD2: if (step) begin
          phase_q <= !phase_q;
          if (phase_q) begin
            state_q <= ST_DONE;
          end
        end
        ST_IDRD: if (step) begin
          phase_q <= !phase_q;
          // Sample at the end of the low half, while the device still drives
          if (!phase_q) begin
            id_q <= {id_q[31:0], i_io};
          end else begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'(ID_BYTES - 1)) begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_POLLR: if (step) begin
          phase_q <= !phase_q;
          if (!phase_q) begin
            status_q <= i_io;
          end else begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
      if (state_q == ST_ADDR && erase_pass_q && ctrl_q[CTRL_OP_LSB +: 3] == OP_ERASE2 &&
          idx_q == 3'h2 && !phase_q && tcnt_q == 4'h0) begin
        xfer_q <= 16'h0000;
      end
    end
  end

  // Per-die busy tracking: set on confirm, cleared by a ready poll or by a reset operation
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      busy_q <= 2'b00;
      rdy_seen_q <= 2'b00;
    end else begin
      rdy_seen_q <= 2'b00;
      if (state_q == ST_POLLR && step && !phase_q) begin
        busy_q[poll_die_q] <= !die_sts_ready;
        rdy_seen_q[poll_die_q] <= die_sts_ready;
      end
      if (state_q == ST_CMD2 && step && phase_q) begin
        busy_q[ctrl_q[CTRL_DIE_BIT]] <= 1'b1;
      end
      if (state_q == ST_DONE && ctrl_q[CTRL_OP_LSB +: 3] == OP_RESET) begin
        busy_q <= 2'b00;
      end
    end
  end

  // Page byte count
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      count_q <= COUNT_RESET;
    end else if (i_wr && i_addr == REG_COUNT) begin
      count_q <= i_wdata;
    end
  end

  // Sticky interrupt status, cleared by reading it; an event wins over the clear
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      irq_stat_q <= 8'h00;
    end else begin
      irq_stat_q <= ((i_rd && i_addr == REG_IRQ_STAT) ? 8'h00 : irq_stat_q) |
                    {4'h0, refuse_ev, rdy_seen_q, irq_done_ev};
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        REG_CTRL: o_rdata <= ctrl_q;
        REG_ADDR_LO: o_rdata <= addr_q[15:0];
        REG_ADDR_HI: o_rdata <= {1'b0, addr_q[30:16]};
        REG_DATA: o_rdata <= {8'h00, data_q};
        REG_STAT: o_rdata <= {3'h0, state_q == ST_IDLE, state_q, status_q[7:6], busy_q,
                              data_vld_q, i_rb_n, cmd_done_sel};
        REG_IRQ_STAT: o_rdata <= {8'h00, irq_stat_q};
        REG_IRQ_MASK: o_rdata <= {8'h00, irq_mask_q};
        REG_ID_LO: o_rdata <= id_q[15:0];
        REG_ID_HI: o_rdata <= id_q[31:16];
        REG_COUNT: o_rdata <= count_q;
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // Flash pins
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_ce_n <= 1'b1;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_re_n <= 1'b1;
      o_io <= 8'h00;
      o_io_oe <= 1'b0;
    end else begin
      // Chip select drops while a load byte is awaited
      o_ce_n <= state_q == ST_IDLE || state_q == ST_DONE ||
                (state_q == ST_DATA && !data_vld_q && !phase_q);
      o_cle <= state_q == ST_CMD1 || state_q == ST_CMD2 || state_q == ST_POLLC;
      o_ale <= state_q == ST_ADDR;
      o_we_n <= !((state_q == ST_CMD1 || state_q == ST_CMD2 || state_q == ST_ADDR ||
                  (state_q == ST_DATA && data_vld_q)) && !phase_q);
      o_re_n <= !((state_q == ST_IDRD || state_q == ST_POLLR) && !phase_q);
      o_io_oe <= state_q == ST_CMD1 || state_q == ST_CMD2 || state_q == ST_ADDR ||
                 state_q == ST_DATA;
      case (state_q)
        ST_CMD1: o_io <= (erase_pass_q ? CMD_ERASE_SETUP : cmd2_q);
        ST_CMD2: o_io <= ctrl_q[CTRL_OP_LSB +: 3] == OP_PROG ? CMD_PROG_CONFIRM :
                         CMD_ERASE_CONFIRM;
        ST_ADDR: o_io <= ctrl_q[CTRL_OP_LSB +: 3] == OP_READID ? ID_ADDR :
                         addr_byte(idx_q, addr_q);
        ST_DATA: o_io <= data_q;
        default: o_io <= 8'h00;
      endcase
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);
endmodule : ndi_host

/* File: sim/ndi_host_checker.sv */
// Pin-level assertions for the dual-die NAND host controller.
// Assumes it sees only the controller's ports through the bind below.
`timescale 1ns/10ps
module ndi_host_checker (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_ce_n,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_we_n,
  input wire logic o_re_n,
  input wire logic [7:0] o_io,
  input wire logic o_io_oe,
  input wire logic [7:0] i_io,
  input wire logic i_rb_n
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  AST_WE_PULSE: assert property ($fell(o_we_n) |-> !o_we_n [*3] ##1 o_we_n [*3])
    else $error("write strobe halves are not three cycles");
  AST_RE_PULSE: assert property ($fell(o_re_n) |-> !o_re_n [*3] ##1 o_re_n [*3])
    else $error("read strobe halves are not three cycles");
  AST_NO_COMBINED: assert property ($fell(o_we_n) && o_cle |-> o_io != 8'h70)
    else $error("combined status read issued");
  AST_CLE_ALE: assert property (!(o_cle && o_ale))
    else $error("command and address latch both high");
  AST_DRIVE_WR: assert property (!o_we_n |-> o_io_oe && !o_ce_n)
    else $error("bus not driven during write strobe");
  AST_READ_FREE: assert property (!o_re_n |-> !o_io_oe && !o_ce_n)
    else $error("bus driven or unselected during read strobe");
  AST_IO_HOLD: assert property (!o_we_n && !$past(o_we_n) |-> $stable(o_io))
    else $error("bus changed inside write strobe");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
endmodule : ndi_host_checker

bind ndi_host ndi_host_checker i_ndi_host_checker (.i_mclk, .i_rstn, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_irq, .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_re_n, .o_io,
  .o_io_oe, .i_io, .i_rb_n);

/* File: sim/ndi_nand_model.sv */
// Behavioural dual-die NAND device facing the host controller.
// Assumes host pins are registered; latches happen on write strobe rise.
`timescale 1ns/10ps
module ndi_nand_model #(
  parameter int T_BUSY = 8000,
  parameter logic [7:0] ID0 = 8'h3c, // Arbitrary value
  parameter logic [7:0] ID1 = 8'ha7, // Arbitrary value
  parameter logic [7:0] ID2 = 8'h41,
  parameter logic [7:0] ID3 = 8'h15,
  parameter logic [7:0] ID4 = 8'h04
) (
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic [7:0] i_io,
  output logic [7:0] o_io,
  output logic o_rb_n
);
  logic [7:0] ab [0:4];
  logic [7:0] buf_q [0:2111];
  logic [7:0] cmd = 8'h00;
  logic sd = 1'b0;
  time t_rdy [0:1] = '{0, 0};
  int na = 0, nd = 0, ri = 0, n60 = 0, e60 = 0, data_cnt = 0;
  initial begin
    o_io = 8'h5a;
    o_rb_n = 1'b1;
  end
  always #5 o_rb_n = ($time >= t_rdy[0]) && ($time >= t_rdy[1]);
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      cmd = i_io;
      if (i_io == 8'h80 || i_io == 8'h85 || i_io == 8'h60) begin
        na = 0;
        nd = 0;
      end
      if (i_io == 8'h60) n60++;
      if (i_io == 8'h90) ri = 0;
      if (i_io == 8'hf1 || i_io == 8'hf2) sd = i_io[1];
      if (i_io == 8'h10 || i_io == 8'hd0) t_rdy[ab[na - 1][2]] = $time + T_BUSY;
      if (i_io == 8'hd0) begin
        e60 = n60;
        n60 = 0;
      end
      if (i_io == 8'hff) t_rdy = '{$time, $time};
    end else if (!i_ce_n && i_ale) begin
      if (na < 5) ab[na] = i_io;
      na++;
    end else if (!i_ce_n && (cmd == 8'h80 || cmd == 8'h85)) begin
      buf_q[{ab[1][3:0], ab[0]} + nd] = i_io;
      nd++;
      data_cnt++;
    end
  end
  always @(negedge i_re_n) begin
    if (!i_ce_n && cmd == 8'h90) begin
      o_io = ri == 0 ? ID0 : ri == 1 ? ID1 : ri == 2 ? ID2 : ri == 3 ? ID3 : ID4;
      ri++;
    end else if (!i_ce_n) begin
      o_io = {1'b1, $time >= t_rdy[sd], 6'h09};
    end
  end
  // Released bus shows the inverse so stale data never looks valid
  always @(posedge i_re_n) #15 o_io = ~o_io;
endmodule : ndi_nand_model

/* File: sim/ndi_host_tb_top.sv */
// Self-checking bench for the dual-die NAND host controller.
// Assumes the device model and the bound checker are compiled with it.
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module ndi_host_tb_top;
  import ndi_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic o_irq, o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_io_oe, rb_n;
  logic [7:0] o_io, dev_io, bus;
  int seed = 32'h1f2e, err_total = 0, comparisons = 0, cyc = 0;
  assign bus = o_io_oe ? o_io : dev_io;
  always #5 i_mclk = ~i_mclk;
  ndi_host i_ndi_host (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
    .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_re_n, .o_io, .o_io_oe, .i_io(bus), .i_rb_n(rb_n));
  ndi_nand_model i_ndi_nand_model (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
    .i_we_n(o_we_n), .i_re_n(o_re_n), .i_io(bus), .o_io(dev_io), .o_rb_n(rb_n));
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic op(input logic [2:0] o, input logic d);
    wr(REG_CTRL, (16'h1 << CTRL_GO_BIT) | 16'(o) | (16'(d) << CTRL_DIE_BIT));
  endtask : op
  task automatic idle(output logic [15:0] s);
    s = 16'h0000;
    for (int k = 0; k < 500 && !s[12]; k++) rd(REG_STAT, s);
  endtask : idle
  task automatic poll(input logic d, output logic [1:0] r);
    logic [15:0] s;
    op(OP_POLL, d);
    idle(s);
    r = s[7:6];
  endtask : poll
  task automatic wait_rdy(input logic d);
    logic [1:0] r;
    r = 2'b00;
    for (int k = 0; k < 300 && r != 2'b11; k++) poll(d, r);
    `CHK("poll ready", 2'b11, r);
  endtask : wait_rdy
  task automatic done(input string t);
    $display("Test %s finished", t);
  endtask : done
  function automatic logic [7:0] abyte(input int i, input logic [30:0] a);
    case (i)
      0: return a[7:0];
      1: return {4'h0, a[11:8]};
      2: return a[19:12];
      3: return a[27:20];
      default: return {5'h00, a[30:28]};
    endcase
  endfunction : abyte
  function automatic logic [30:0] rnd_addr(input logic d);
    logic [30:0] v;
    v = 31'($random(seed));
    v[11] = 1'b0;
    v[30] = d;
    return v;
  endfunction : rnd_addr
  task automatic set_addr(input logic [30:0] a);
    wr(REG_ADDR_LO, a[15:0]);
    wr(REG_ADDR_HI, {1'b0, a[30:16]});
  endtask : set_addr
  task automatic prog(input logic [2:0] o, input logic [30:0] a, input int n);
    logic [15:0] s;
    logic [7:0] b [0:7];
    int c0;
    c0 = i_ndi_nand_model.data_cnt;
    set_addr(a);
    wr(REG_COUNT, 16'(n));
    op(o, a[30]);
    for (int i = 0; i < n; i++) begin
      b[i] = 8'($random(seed));
      s = 16'h0008;
      for (int k = 0; k < 200 && s[3]; k++) rd(REG_STAT, s);
      wr(REG_DATA, {8'h00, b[i]});
    end
    idle(s);
    `CHK("data count", n, i_ndi_nand_model.data_cnt - c0);
    for (int i = 0; i < 5; i++) `CHK("addr", abyte(i, a), i_ndi_nand_model.ab[i]);
    for (int i = 0; i < n; i++) `CHK("page", b[i], i_ndi_nand_model.buf_q[a[11:0] + i]);
  endtask : prog
  initial begin
    logic [15:0] s;
    logic [1:0] r;
    logic [30:0] a;
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rd(REG_IRQ_MASK, s);
    `CHK("mask reset", 16'(MASK_RESET), s);
    wr(REG_IRQ_MASK, 16'h0008);
    rd(4'hf, s);
    op(OP_READID, 1'b0);
    idle(s);
    rd(REG_ID_HI, s);
    `CHK("id hi", {i_ndi_nand_model.ID1, i_ndi_nand_model.ID2}, s);
    rd(REG_ID_LO, s);
    `CHK("id lo", {i_ndi_nand_model.ID3, i_ndi_nand_model.ID4}, s);
    `CHK("irq masked", 1'b0, o_irq);
    rd(REG_IRQ_STAT, s);
    `CHK("done bit", 1'b1, s[IRQ_DONE]);
    done("read id");
    prog(OP_PROG, rnd_addr(1'b0), 4);
    prog(OP_PROG, rnd_addr(1'b1), 3);
    rd(REG_STAT, s);
    `CHK("both busy", 2'b11, s[5:4]);
    rd(REG_IRQ_STAT, s);
    op(OP_PROG, 1'b0);
    repeat (3) @(posedge i_mclk);
    #1 `CHK("irq raised", 1'b1, o_irq);
    rd(REG_IRQ_STAT, s);
    `CHK("refused", 1'b1, s[IRQ_REFUSED]);
    `CHK("irq cleared", 1'b0, o_irq);
    poll(1'b0, r);
    `CHK("poll busy", 2'b10, r);
    wait_rdy(1'b0);
    rd(REG_STAT, s);
    `CHK("die free", 1'b0, s[4]);
    rd(REG_IRQ_STAT, s);
    `CHK("ready irq", 1'b1, s[IRQ_D1_RDY]);
    done("interleaved program");
    a = rnd_addr(1'b0);
    set_addr(a);
    op(OP_ERASE2, 1'b0);
    idle(s);
    `CHK("planes", 2, i_ndi_nand_model.e60);
    for (int i = 0; i < 3; i++) `CHK("row", abyte(i + 2, a), i_ndi_nand_model.ab[i]);
    op(OP_ERASE, 1'b1);
    rd(REG_IRQ_STAT, s);
    `CHK("erase refused", 1'b1, s[IRQ_REFUSED]);
    wait_rdy(1'b1);
    set_addr(rnd_addr(1'b1));
    op(OP_ERASE, 1'b1);
    idle(s);
    `CHK("both erasing", 2'b11, s[5:4]);
    wait_rdy(1'b0);
    done("interleaved erase");
    op(OP_RESET, 1'b0);
    idle(s);
    `CHK("reset ready", 3'b001, {s[5:4], s[2]});
    prog(OP_RDIN, rnd_addr(1'b0), 2);
    done("reset and random input");
    report_and_stop();
  end
endmodule : ndi_host_tb_top
